// file: design/pulse_gen_pkg.sv
package pulse_gen_pkg;

	// Clock rate and the derived number of clock cycles per millisecond.
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CLK_PER_MS_DEFAULT = CLK_HZ / MS_PER_S;
	localparam int MS_CNT_W = 17;

	// Avalon byte addresses of the register words.
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_INPUT = 5'h04;
	localparam logic [4:0] OFF_PERIOD = 5'h08;
	localparam logic [4:0] OFF_MIN_PB = 5'h0C;
	localparam logic [4:0] OFF_RATIO = 5'h10;
	localparam logic [4:0] OFF_SAMPLE = 5'h14;
	localparam logic [4:0] OFF_STATUS = 5'h18;

	// Status word field positions.
	localparam int ST_POS_BIT = 0;
	localparam int ST_NEG_BIT = 1;
	localparam int ST_ERR_LSB = 8;
	localparam int ST_ELAPSED_LSB = 16;

	// Values after reset.
	localparam logic [6:0] CTRL_RESET = 7'h21;
	localparam logic [15:0] INPUT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_MS_RESET = 16'h03E8;
	localparam logic [15:0] MIN_PB_MS_RESET = 16'h0032;
	localparam logic [15:0] RATIO_RESET = 16'h0100;
	localparam logic [15:0] SAMPLE_MS_RESET = 16'h000A;
	localparam logic [7:0] ERROR_RETURN_VALUE = 8'h00;

	// The input is signed hundredths of a percent; the ratio is unsigned 8.8.
	localparam logic [15:0] FULL_SCALE = 16'h2710;
	localparam logic [15:0] RATIO_ONE = 16'h0100;
	localparam int RATIO_FRAC_BITS = 8;

	typedef struct packed {
		logic complete_restart_request;
		logic period_resync_enable;
		logic manual_negative_request;
		logic manual_positive_request;
		logic manual_override_select;
		logic bipolar_two_level_select;
		logic three_level_select;
	} ctrl_t;

	typedef struct packed {
		logic [15:0] pos;
		logic [15:0] neg;
	} pulse_pair_t;

	typedef enum logic [1:0] {
		MODE_THREE = 2'b00,
		MODE_BIPOLAR = 2'b01,
		MODE_MONOPOLAR = 2'b10,
		MODE_MANUAL = 2'b11
	} mode_t;

endpackage

// file: design/pulse_duration_calc.sv
`timescale 1ns/1ps
module pulse_duration_calc
	import pulse_gen_pkg::*;
(
	input wire mode_t mode,
	input wire logic signed [15:0] duty_input_value,
	input wire logic [15:0] period_ms,
	input wire logic [15:0] min_pb_ms,
	input wire logic [15:0] ratio,
	output pulse_pair_t dur
);

	logic [15:0] mag;
	logic [31:0] raw;
	logic [31:0] pos_raw;
	logic [31:0] neg_raw;
	logic [31:0] thr_neg;
	logic signed [16:0] biased;

	// Short pulses vanish and near-full pulses fill the whole period.
	function automatic logic [15:0] shape(input logic [31:0] d, input logic [31:0] thr,
			input logic [15:0] per);
		if (d < thr)
			shape = 16'h0000;
		else if (d + thr > {16'h0000, per})
			shape = per;
		else
			shape = d[15:0];
	endfunction

	always_comb
	begin
		biased = 17'(duty_input_value) + 17'(signed'({1'b0, FULL_SCALE}));
		case (mode)
			MODE_THREE:
				mag = duty_input_value[15] ? 16'(-duty_input_value) : duty_input_value;
			MODE_BIPOLAR:
				mag = biased[16] ? 16'h0000 : biased[16:1];
			MODE_MONOPOLAR:
				mag = duty_input_value[15] ? 16'h0000 : duty_input_value;
			default:
				mag = 16'h0000;
		endcase
		if (mag > FULL_SCALE)
			mag = FULL_SCALE;
		raw = (32'(mag) * 32'(period_ms)) / 32'(FULL_SCALE);
		if (ratio > RATIO_ONE)
			pos_raw = (raw << RATIO_FRAC_BITS) / 32'(ratio);
		else
			pos_raw = raw;
		if (ratio < RATIO_ONE)
		begin
			neg_raw = (raw * 32'(ratio)) >> RATIO_FRAC_BITS;
			thr_neg = (32'(min_pb_ms) * 32'(ratio)) >> RATIO_FRAC_BITS;
		end
		else
		begin
			neg_raw = raw;
			thr_neg = 32'(min_pb_ms);
		end
		dur.pos = 16'h0000;
		dur.neg = 16'h0000;
		if (mode == MODE_THREE)
		begin
			if (!duty_input_value[15])
				dur.pos = shape(pos_raw, 32'(min_pb_ms), period_ms);
			else
				dur.neg = shape(neg_raw, thr_neg, period_ms);
		end
		else if (mode != MODE_MANUAL)
			dur.pos = shape(raw, 32'(min_pb_ms), period_ms);
	end

endmodule

// file: design/pulse_duration_step_generator.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Manual first, then three-level, then bipolar select.
// - Three-level: positive and negative never both high.
// - Pulse length equals input over 10000 times period; bipolar uses (input + 10000) / 2 as input.
// - Pulses shorter than minimum time are suppressed.
// - Pulses near full period fill whole period.
// - Ratio below one scales negative pulses down.
// - Ratio below one scales negative threshold too.
// - Ratio above one divides positive pulses.
// - Two-level: negative output is inverse of positive.
// - Manual three-level copies requests; both gives zero.
// - Manual two-level: negative is inverse of positive.
// - Restart request forces both outputs to zero.
// - No error checking; error value stays zero.
// - Resync enable realigns period to input changes.
// - Resync skips first and last two calls.
// - Three-level select defaults true, uses both outputs.
// - Output active for leading calls, then inactive.
module pulse_duration_step_generator
	import pulse_gen_pkg::*;
#(
	parameter int CLK_PER_MS = CLK_PER_MS_DEFAULT
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic positive_pulse_out,
	output logic negative_pulse_out
);

	generate
		if (CLK_PER_MS < 1 || CLK_PER_MS > (1 << MS_CNT_W))
		begin : g_bad_rate
			$error("CLK_PER_MS out of range for the millisecond prescaler");
		end
	endgenerate

	// Register file state.
	ctrl_t ctrl_reg;
	ctrl_t ctrl_next;
	logic [15:0] duty_reg;
	logic [15:0] duty_next;
	logic [15:0] per_reg;
	logic [15:0] per_next;
	logic [15:0] pb_reg;
	logic [15:0] pb_next;
	logic [15:0] ratio_reg;
	logic [15:0] ratio_next;
	logic [15:0] cyc_reg;
	logic [15:0] cyc_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Modulation state.
	logic [MS_CNT_W-1:0] ms_cnt_reg;
	logic [MS_CNT_W-1:0] ms_cnt_next;
	logic [15:0] call_cnt_reg;
	logic [15:0] call_cnt_next;
	logic [15:0] elapsed_reg;
	logic [15:0] elapsed_next;
	pulse_pair_t dur_reg;
	pulse_pair_t dur_next;
	logic [15:0] duty_seen_reg;
	logic [15:0] duty_seen_next;
	logic pwm_pos_reg;
	logic pwm_pos_next;
	logic pwm_neg_reg;
	logic pwm_neg_next;
	logic pos_out_reg;
	logic pos_out_next;
	logic neg_out_reg;
	logic neg_out_next;

	mode_t mode;
	pulse_pair_t dur_calc;
	pulse_pair_t dur_use;
	logic [15:0] cyc_eff;
	logic ms_tick;
	logic call_tick;
	logic period_start;
	logic [16:0] elapsed_adv;
	logic [17:0] two_calls_on;
	logic resync;
	logic wr_take;
	logic rd_take;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	always_comb
	begin
		if (ctrl_reg.manual_override_select)
			mode = MODE_MANUAL;
		else if (ctrl_reg.three_level_select)
			mode = MODE_THREE;
		else if (ctrl_reg.bipolar_two_level_select)
			mode = MODE_BIPOLAR;
		else
			mode = MODE_MONOPOLAR;
	end

	pulse_duration_calc u_calc (
		.mode(mode),
		.duty_input_value(duty_reg),
		.period_ms(per_reg),
		.min_pb_ms(pb_reg),
		.ratio(ratio_reg),
		.dur(dur_calc)
	);

	// Avalon slave: one wait state on every access, then the access completes.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign avs_readdata = rdata_reg;
	assign wr_take = avs_write & ack_reg;
	assign rd_take = avs_read & ~ack_reg;

	always_comb
	begin
		ack_next = (avs_read | avs_write) & ~ack_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		duty_next = duty_reg;
		per_next = per_reg;
		pb_next = pb_reg;
		ratio_next = ratio_reg;
		cyc_next = cyc_reg;
		if (rd_take)
		begin
			case (avs_address)
				OFF_CTRL: rdata_next = {25'h000_0000, ctrl_reg};
				OFF_INPUT: rdata_next = {16'h0000, duty_reg};
				OFF_PERIOD: rdata_next = {16'h0000, per_reg};
				OFF_MIN_PB: rdata_next = {16'h0000, pb_reg};
				OFF_RATIO: rdata_next = {16'h0000, ratio_reg};
				OFF_SAMPLE: rdata_next = {16'h0000, cyc_reg};
				OFF_STATUS:
				begin
					rdata_next = 32'h0000_0000;
					rdata_next[ST_POS_BIT] = pos_out_reg;
					rdata_next[ST_NEG_BIT] = neg_out_reg;
					rdata_next[ST_ERR_LSB +: 8] = ERROR_RETURN_VALUE;
					rdata_next[ST_ELAPSED_LSB +: 16] = elapsed_reg;
				end
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		if (wr_take)
		begin
			case (avs_address)
				OFF_CTRL:
					ctrl_next = ctrl_t'(7'(be_merge({25'h000_0000, ctrl_reg}, avs_writedata,
						avs_byteenable)));
				OFF_INPUT:
					duty_next = 16'(be_merge({16'h0000, duty_reg}, avs_writedata,
						avs_byteenable));
				OFF_PERIOD:
					per_next = 16'(be_merge({16'h0000, per_reg}, avs_writedata, avs_byteenable));
				OFF_MIN_PB:
					pb_next = 16'(be_merge({16'h0000, pb_reg}, avs_writedata, avs_byteenable));
				OFF_RATIO:
					ratio_next = 16'(be_merge({16'h0000, ratio_reg}, avs_writedata,
						avs_byteenable));
				OFF_SAMPLE:
					cyc_next = 16'(be_merge({16'h0000, cyc_reg}, avs_writedata, avs_byteenable));
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg <= ctrl_t'(CTRL_RESET);
			duty_reg <= INPUT_RESET;
			per_reg <= PERIOD_MS_RESET;
			pb_reg <= MIN_PB_MS_RESET;
			ratio_reg <= RATIO_RESET;
			cyc_reg <= SAMPLE_MS_RESET;
		end
		else
		begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			duty_reg <= duty_next;
			per_reg <= per_next;
			pb_reg <= pb_next;
			ratio_reg <= ratio_next;
			cyc_reg <= cyc_next;
		end
	end

	// A zero sample interval would stall the period, so it counts as one millisecond.
	assign cyc_eff = (cyc_reg == 16'h0000) ? 16'h0001 : cyc_reg;
	assign ms_tick = (ms_cnt_reg == MS_CNT_W'(CLK_PER_MS - 1));
	assign call_tick = ms_tick && (call_cnt_reg >= cyc_eff - 16'h0001);
	assign period_start = (elapsed_reg == 16'h0000);
	assign dur_use = period_start ? dur_calc : dur_reg;
	assign elapsed_adv = {1'b0, elapsed_reg} + {1'b0, cyc_eff};
	assign two_calls_on = {2'b00, elapsed_reg} + {1'b0, cyc_eff, 1'b0};
	// Time within the period is kept in milliseconds, so no division by the interval is needed.
	assign resync = ctrl_reg.period_resync_enable && !period_start
		&& (duty_reg != duty_seen_reg) && (two_calls_on < {2'b00, per_reg});

	always_comb
	begin
		ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + MS_CNT_W'(1);
		call_cnt_next = call_cnt_reg;
		elapsed_next = elapsed_reg;
		dur_next = dur_reg;
		duty_seen_next = duty_seen_reg;
		pwm_pos_next = pwm_pos_reg;
		pwm_neg_next = pwm_neg_reg;
		if (ms_tick)
			call_cnt_next = call_tick ? 16'h0000 : call_cnt_reg + 16'h0001;
		if (ctrl_reg.complete_restart_request)
		begin
			ms_cnt_next = '0;
			call_cnt_next = 16'h0000;
			elapsed_next = 16'h0000;
			pwm_pos_next = 1'b0;
			pwm_neg_next = 1'b0;
		end
		else if (call_tick)
		begin
			if (period_start)
			begin
				dur_next = dur_calc;
				duty_seen_next = duty_reg;
			end
			pwm_pos_next = elapsed_reg < dur_use.pos;
			pwm_neg_next = elapsed_reg < dur_use.neg;
			if (resync)
				elapsed_next = 16'h0000;
			else if (elapsed_adv >= {1'b0, per_reg})
				elapsed_next = 16'h0000;
			else
				elapsed_next = elapsed_adv[15:0];
		end
	end

	always_comb
	begin
		if (ctrl_reg.complete_restart_request)
		begin
			pos_out_next = 1'b0;
			neg_out_next = 1'b0;
		end
		else
		begin
			case (mode)
				MODE_MANUAL:
				begin
					if (ctrl_reg.three_level_select)
					begin
						pos_out_next = ctrl_reg.manual_positive_request
							& ~ctrl_reg.manual_negative_request;
						neg_out_next = ctrl_reg.manual_negative_request
							& ~ctrl_reg.manual_positive_request;
					end
					else
					begin
						pos_out_next = ctrl_reg.manual_positive_request;
						neg_out_next = ~ctrl_reg.manual_positive_request;
					end
				end
				MODE_THREE:
				begin
					pos_out_next = pwm_pos_reg & ~pwm_neg_reg;
					neg_out_next = pwm_neg_reg & ~pwm_pos_reg;
				end
				MODE_BIPOLAR, MODE_MONOPOLAR:
				begin
					pos_out_next = pwm_pos_reg;
					neg_out_next = ~pwm_pos_reg;
				end
				default:
				begin
					pos_out_next = 1'b0;
					neg_out_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ms_cnt_reg <= '0;
			call_cnt_reg <= 16'h0000;
			elapsed_reg <= 16'h0000;
			dur_reg <= '0;
			duty_seen_reg <= INPUT_RESET;
			pwm_pos_reg <= 1'b0;
			pwm_neg_reg <= 1'b0;
			pos_out_reg <= 1'b0;
			neg_out_reg <= 1'b0;
		end
		else
		begin
			ms_cnt_reg <= ms_cnt_next;
			call_cnt_reg <= call_cnt_next;
			elapsed_reg <= elapsed_next;
			dur_reg <= dur_next;
			duty_seen_reg <= duty_seen_next;
			pwm_pos_reg <= pwm_pos_next;
			pwm_neg_reg <= pwm_neg_next;
			pos_out_reg <= pos_out_next;
			neg_out_reg <= neg_out_next;
		end
	end

	assign positive_pulse_out = pos_out_reg;
	assign negative_pulse_out = neg_out_reg;

endmodule

// file: test/lmn_source.sv
`timescale 1ns/1ps
module controller_model
	import pulse_gen_pkg::*;
(
	input wire logic [31:0] raw_value,
	output logic [15:0] manip_value,
	output logic [15:0] period_ms,
	output logic [15:0] min_pb_ms,
	output logic [15:0] sample_ms
);
	// The controller never hands over a value beyond full scale either way.
	assign manip_value = 16'(raw_value % 32'h0000_4E21 - {16'h0000, FULL_SCALE});
	assign sample_ms = 16'h0001;
	// Twenty calls per period keeps the output resolution at five percent.
	assign period_ms = 16'h0014;
	assign min_pb_ms = 16'h0002;
endmodule

// file: test/pulse_gen_sva.sv
`timescale 1ns/1ps
module pulse_gen_sva
	import pulse_gen_pkg::*;
#(
	parameter int CLK_PER_MS = CLK_PER_MS_DEFAULT
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic positive_pulse_out,
	input wire logic negative_pulse_out
);
	logic ctrl_acc;
	logic [6:0] ctrl_reg;
	logic [6:0] ctrl_next;
	logic [3:0] age_reg;
	logic [3:0] age_next;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	assign ctrl_acc = avs_write && !avs_waitrequest && avs_address == OFF_CTRL && avs_byteenable[0];
	sequence ctrl_wr;
		ctrl_acc;
	endsequence
	sequence stat_rd;
		avs_read && !avs_waitrequest && avs_address == OFF_STATUS;
	endsequence
	// The output stage needs a call and a register stage to follow a mode change.
	always_comb
	begin
		ctrl_next = ctrl_acc ? avs_writedata[6:0] : ctrl_reg;
		age_next = ctrl_acc ? 4'h0 : ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);
	end
	always_ff @(posedge ref_clk)
	begin
		ctrl_reg <= rst ? CTRL_RESET : ctrl_next;
		age_reg <= rst ? 4'h0 : age_next;
	end
	never_both_a: assert property (!(positive_pulse_out && negative_pulse_out))
		else $error("both outputs high");
	release_idle_a: assert property ($fell(rst) |-> !positive_pulse_out && !negative_pulse_out)
		else $error("outputs active after reset");
	restart_zero_a: assert property (ctrl_wr ##0 avs_writedata[6] |->
		##2 (!positive_pulse_out && !negative_pulse_out) [*3]) else $error("restart not zero");
	manual_three_a: assert property (ctrl_wr ##0 (avs_writedata[2] && avs_writedata[0] &&
		!avs_writedata[6]) |-> ##2 (positive_pulse_out == ($past(avs_writedata[3], 2) &&
		!$past(avs_writedata[4], 2)) && negative_pulse_out == ($past(avs_writedata[4], 2) &&
		!$past(avs_writedata[3], 2)))) else $error("manual three-level mismatch");
	manual_two_a: assert property (ctrl_wr ##0 (avs_writedata[2] && !avs_writedata[0] &&
		!avs_writedata[6]) |-> ##2 positive_pulse_out == $past(avs_writedata[3], 2) &&
		negative_pulse_out != positive_pulse_out) else $error("manual two-level mismatch");
	two_inverse_a: assert property (!ctrl_reg[0] && !ctrl_reg[6] && age_reg == 4'hF |->
		negative_pulse_out == !positive_pulse_out) else $error("two-level not inverse");
	error_zero_a: assert property (stat_rd |-> avs_readdata[15:8] == ERROR_RETURN_VALUE)
		else $error("error field set");
	wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |->
		avs_waitrequest) else $error("no wait state");
	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
endmodule
bind pulse_duration_step_generator pulse_gen_sva #(.CLK_PER_MS(CLK_PER_MS)) chk (
	.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.positive_pulse_out(positive_pulse_out), .negative_pulse_out(negative_pulse_out));

// file: test/pulse_duration_step_generator_tb.sv
`timescale 1ns/1ps
module pulse_duration_step_generator_tb;
	import pulse_gen_pkg::*;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
	// Output clocks per pulse millisecond over a ten-period window at two clocks per ms.
	localparam int K = 20;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic positive_pulse_out;
	logic negative_pulse_out;
	logic [31:0] raw_value = 32'h0000_0000;
	logic [15:0] manip_value, period_ms, min_pb_ms, sample_ms, pc, nc;
	logic [31:0] rd_q[$];
	logic [31:0] cnt_q[$];
	logic [31:0] exp_v;
	logic win_on = 1'b0;
	int fail_count = 0;
	int num_checks = 0;
	logic [6:0] ct [18] = '{7'h21, 7'h21, 7'h21, 7'h21, 7'h21, 7'h21, 7'h21, 7'h21, 7'h22,
		7'h22, 7'h20, 7'h20, 7'h2D, 7'h3D, 7'h37, 7'h3E, 7'h34, 7'h61};
	int inp [18] = '{5000, -2500, 500, 9500, -9500, -5000, -1000, 5000, 0, 10000, -5000, 2500,
		0, 0, 0, 0, 0, 5000};
	int pm [18] = '{10, 0, 0, 20, 0, 0, 0, 5, 10, 20, 0, 5, 20, 0, 0, 20, 0, 0};
	int nm [18] = '{0, 5, 0, 0, 20, 5, 1, 0, 10, 0, 20, 15, 0, 0, 20, 0, 20, 0};
	pulse_duration_step_generator #(.CLK_PER_MS(2)) uut (.ref_clk(ref_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .positive_pulse_out(positive_pulse_out),
		.negative_pulse_out(negative_pulse_out));
	controller_model ctl (.raw_value(raw_value), .manip_value(manip_value), .period_ms(period_ms),
		.min_pb_ms(min_pb_ms), .sample_ms(sample_ms));
	initial
		forever #5 ref_clk = ~ref_clk;
	task report_and_stop;
		$display("checks=%0d errors=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task hang;
		fail_count++;
		report_and_stop();
	endtask
	task bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
		int n;
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest && n < 50);
		if (n >= 50)
			hang();
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b1, a, 32'h0000_0000);
	endtask
	task meas(input logic [31:0] e);
		repeat (100) @(posedge ref_clk);
		win_on <= 1'b1;
		repeat (K * int'(period_ms)) @(posedge ref_clk);
		win_on <= 1'b0;
		cnt_q.push_back(e);
		// Two edges let the watcher compare before the caller may end the run.
		repeat (2) @(posedge ref_clk);
	endtask
	function automatic logic [31:0] exp_cnt(input logic signed [15:0] v);
		int a;
		int d;
		a = (v < 0) ? -v : v;
		d = a * int'(period_ms) / int'(FULL_SCALE);
		d = (d < int'(min_pb_ms)) ? 0 : ((d + int'(min_pb_ms) > int'(period_ms)) ? period_ms : d);
		return (v < 0) ? {16'h0000, 16'(d * K)} : {16'(d * K), 16'h0000};
	endfunction
	always @(posedge ref_clk)
	begin
		if (avs_read && !avs_waitrequest && rd_q.size() > 0)
		begin
			exp_v = rd_q.pop_front();
			`CHK(avs_readdata, exp_v)
		end
		if (win_on)
		begin
			pc = pc + {15'h0000, positive_pulse_out};
			nc = nc + {15'h0000, negative_pulse_out};
		end
		else if (cnt_q.size() > 0)
		begin
			exp_v = cnt_q.pop_front();
			`CHK({pc, nc}, exp_v)
		end
		else
		begin
			pc = 16'h0000;
			nc = 16'h0000;
		end
	end
	initial
	begin
		int k;
		raw_value = $urandom(57363);
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFF_CTRL, {25'h0000_000, CTRL_RESET});
		rd(OFF_PERIOD, {16'h0000, PERIOD_MS_RESET});
		rd(OFF_MIN_PB, {16'h0000, MIN_PB_MS_RESET});
		rd(OFF_RATIO, {16'h0000, RATIO_RESET});
		rd(OFF_SAMPLE, {16'h0000, SAMPLE_MS_RESET});
		rd(OFF_INPUT, 32'h0000_0000);
		bus(1'b0, 5'h1C, 32'hFFFF_FFFF);
		rd(5'h1C, 32'h0000_0000);
		bus(1'b0, OFF_PERIOD, {16'h0000, period_ms});
		bus(1'b0, OFF_MIN_PB, {16'h0000, min_pb_ms});
		bus(1'b0, OFF_SAMPLE, {16'h0000, sample_ms});
		rd(OFF_PERIOD, {16'h0000, period_ms});
		for (int i = 0; i < 18; i++)
		begin
			bus(1'b0, OFF_RATIO, (i == 5 || i == 6) ? 32'h0000_0080 : ((i == 7) ? 32'h0000_0200 :
				{16'h0000, RATIO_ONE}));
			bus(1'b0, OFF_INPUT, 32'(inp[i]));
			bus(1'b0, OFF_CTRL, {25'h0000_000, ct[i]});
			meas({16'(pm[i] * K), 16'(nm[i] * K)});
		end
		rd(OFF_STATUS, 32'h0000_0000);
		bus(1'b0, OFF_RATIO, {16'h0000, RATIO_ONE});
		bus(1'b0, OFF_INPUT, 32'h0000_0000);
		bus(1'b0, OFF_CTRL, 32'h0000_0021);
		repeat (100) @(posedge ref_clk);
		bus(1'b0, OFF_INPUT, 32'h0000_1388);
		k = 0;
		while (!positive_pulse_out && k < 16)
		begin
			@(posedge ref_clk);
			k++;
		end
		`CHK(positive_pulse_out, 1'b1)
		for (int i = 0; i < 4; i++)
		begin
			raw_value = $urandom;
			@(posedge ref_clk);
			bus(1'b0, OFF_INPUT, {{16{manip_value[15]}}, manip_value});
			meas(exp_cnt(manip_value));
		end
		report_and_stop();
	end
endmodule
